// >>> pkg/ses_cfg.svh
// Constants of the status event summary block: selects, bit positions, reset values.
// Assumes it is included by its bare name from the package and the design file.
`ifndef SES_CFG_SVH
`define SES_CFG_SVH

// Register selects on the command port
`define SES_SEL_STATUS_BYTE   4'h0
`define SES_SEL_SRQ_MASK      4'h1
`define SES_SEL_STD_LATCH     4'h2
`define SES_SEL_STD_MASK      4'h3
`define SES_SEL_SRC_COND      4'h4
`define SES_SEL_RISE_SELECT   4'h5
`define SES_SEL_FALL_SELECT   4'h6
`define SES_SEL_SRC_LATCH     4'h7
`define SES_SEL_SRC_MASK      4'h8

// Status byte fields
`define SES_SB_SRC_SUMMARY    0
`define SES_SB_EVT_SUMMARY    5
`define SES_SB_MASTER         6

// Standard event latch fields
`define SES_STD_OPC           0
`define SES_STD_QUERY_ERR     2
`define SES_STD_DEV_ERR       3
`define SES_STD_EXEC_ERR      4
`define SES_STD_CMD_ERR       5
`define SES_STD_USER_REQ      6
`define SES_STD_VALID_BITS    8'h7D

// Source condition and latch fields
`define SES_COND_OVERLOAD     0
`define SES_COND_INTERLOCK    1
`define SES_SRC_SCAN_DONE     6
`define SES_SRC_SCAN_CANCEL   7

// Writable bits of the service request mask
`define SES_SRQ_VALID_BITS    8'hBF

// Reset value of every register
`define SES_RESET_BYTE        8'h00

`endif

// >>> pkg/ses_pkg.sv
// Types of the status event summary block.
// Assumes ses_cfg.svh is reachable on the include path.
`include "ses_cfg.svh"

package ses_pkg;

  typedef logic [7:0] ses_byte_t;
  typedef logic [3:0] ses_sel_t;
  typedef logic [2:0] ses_bit_t;
  typedef logic [1:0] ses_cond_t;

endpackage

// >>> hdl/ses_status_event_summary.sv
// Status event summary: condition, transition select, sticky latches, masks, status byte.
// Assumes a command parser drives the command port one request per cycle at most,
// and that event inputs are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
`include "ses_cfg.svh"

module ses_status_event_summary (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Command port
  input  wire logic             cmd_valid_i,
  input  wire logic             cmd_write_i,
  input  wire ses_pkg::ses_sel_t cmd_sel_i,
  input  wire logic             cmd_single_i,
  input  wire ses_pkg::ses_bit_t cmd_bit_i,
  input  wire ses_pkg::ses_byte_t cmd_wdata_i,
  input  wire logic             clear_status_i,
  output logic                  rsp_valid_o,
  output ses_pkg::ses_byte_t    rsp_data_o,
  // Event sources
  input  wire logic             opc_cmd_i,
  input  wire logic             query_lost_i,
  input  wire logic             overflow_i,
  input  wire logic             exec_err_i,
  input  wire logic             cmd_err_i,
  input  wire logic             button_i,
  input  wire logic             scan_cancel_i,
  input  wire logic             scan_done_i,
  input  wire logic             overload_flag_i,
  input  wire logic             interlock_i,
  // Summary outputs
  output ses_pkg::ses_byte_t    status_byte_o,
  output logic                  mss_o
);
  import ses_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One-hot for a single-bit access, all ones for a whole-byte access
  function automatic ses_byte_t bit_mask(input logic single, input ses_bit_t idx);
    ses_byte_t m;
    m = 8'h01 << idx;
    return single ? m : 8'hFF;
  endfunction

  // Value returned to the host: one bit in bit 0, or the whole byte
  function automatic ses_byte_t pick(input logic single, input ses_bit_t idx, input ses_byte_t v);
    return single ? {7'h00, v[idx]} : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  ses_byte_t srq_mask;
  ses_byte_t std_latch;
  ses_byte_t std_mask;
  ses_byte_t rise_select;
  ses_byte_t fall_select;
  ses_byte_t src_latch;
  ses_byte_t src_mask;
  ses_cond_t cond_prev;

  ses_cond_t source_condition;
  ses_byte_t cmd_mask;
  ses_byte_t wr_value;
  logic      do_read;
  logic      do_write;
  logic      source_summary_bit;
  logic      evt_summary;
  ses_byte_t status_pre;
  ses_byte_t status_byte;
  logic      mss;
  ses_byte_t std_set;
  ses_byte_t src_set;
  ses_byte_t std_clr;
  ses_byte_t src_clr;
  ses_byte_t next_std_latch;
  ses_byte_t next_src_latch;
  ses_byte_t next_rsp;

  always_comb begin
    source_condition                      = 2'b00;
    source_condition[`SES_COND_OVERLOAD]  = overload_flag_i;
    source_condition[`SES_COND_INTERLOCK] = interlock_i;
  end

  assign do_read  = cmd_valid_i & ~cmd_write_i;
  assign do_write = cmd_valid_i & cmd_write_i;
  assign cmd_mask = bit_mask(cmd_single_i, cmd_bit_i);

  // Single-bit write sets or clears the addressed bit; whole write loads the byte
  function automatic ses_byte_t merge(input ses_byte_t cur);
    if (cmd_single_i) begin
      return cmd_wdata_i[0] ? (cur | cmd_mask) : (cur & ~cmd_mask);
    end
    return cmd_wdata_i;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Summaries

  always_comb begin
    source_summary_bit = |(src_latch & src_mask);
    evt_summary        = |(std_latch & std_mask);
    status_pre                      = `SES_RESET_BYTE;
    status_pre[`SES_SB_SRC_SUMMARY] = source_summary_bit;
    status_pre[`SES_SB_EVT_SUMMARY] = evt_summary;
    mss                             = |(status_pre & srq_mask);
    status_byte                     = status_pre;
    status_byte[`SES_SB_MASTER]     = mss;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sets and clears

  always_comb begin
    std_set = `SES_RESET_BYTE;
    std_set[`SES_STD_OPC]       = opc_cmd_i;
    std_set[`SES_STD_QUERY_ERR] = query_lost_i;
    std_set[`SES_STD_DEV_ERR]   = overflow_i;
    std_set[`SES_STD_EXEC_ERR]  = exec_err_i;
    std_set[`SES_STD_CMD_ERR]   = cmd_err_i;
    std_set[`SES_STD_USER_REQ]  = button_i;

    src_set = `SES_RESET_BYTE;
    src_set[1:0] = (source_condition & ~cond_prev & rise_select[1:0]) |
                   (~source_condition & cond_prev & fall_select[1:0]);
    src_set[`SES_SRC_SCAN_DONE]   = scan_done_i;
    src_set[`SES_SRC_SCAN_CANCEL] = scan_cancel_i;

    // clears by read or clear command
    std_clr = clear_status_i ? 8'hFF : `SES_RESET_BYTE;
    src_clr = clear_status_i ? 8'hFF : `SES_RESET_BYTE;
    if (do_read && cmd_sel_i == `SES_SEL_STD_LATCH) begin
      std_clr = std_clr | cmd_mask;
    end
    if (do_read && cmd_sel_i == `SES_SEL_SRC_LATCH) begin
      src_clr = src_clr | cmd_mask;
    end

    next_std_latch = ((std_latch & ~std_clr) | std_set) & `SES_STD_VALID_BITS;
    next_src_latch = (src_latch & ~src_clr) | src_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    case (cmd_sel_i)
      `SES_SEL_STATUS_BYTE: next_rsp = pick(cmd_single_i, cmd_bit_i, status_byte);
      `SES_SEL_SRQ_MASK:    next_rsp = pick(cmd_single_i, cmd_bit_i, srq_mask);
      `SES_SEL_STD_LATCH:   next_rsp = pick(cmd_single_i, cmd_bit_i, std_latch);
      `SES_SEL_STD_MASK:    next_rsp = pick(cmd_single_i, cmd_bit_i, std_mask);
      `SES_SEL_SRC_COND:    next_rsp = pick(cmd_single_i, cmd_bit_i, {6'h00, source_condition});
      `SES_SEL_RISE_SELECT: next_rsp = pick(cmd_single_i, cmd_bit_i, rise_select);
      `SES_SEL_FALL_SELECT: next_rsp = pick(cmd_single_i, cmd_bit_i, fall_select);
      `SES_SEL_SRC_LATCH:   next_rsp = pick(cmd_single_i, cmd_bit_i, src_latch);
      `SES_SEL_SRC_MASK:    next_rsp = pick(cmd_single_i, cmd_bit_i, src_mask);
      default:              next_rsp = `SES_RESET_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      std_latch <= `SES_RESET_BYTE;
      src_latch <= `SES_RESET_BYTE;
      cond_prev <= 2'b00;
    end else if (ce_i) begin
      std_latch <= next_std_latch;
      src_latch <= next_src_latch;
      cond_prev <= source_condition;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_mask    <= `SES_RESET_BYTE;
      std_mask    <= `SES_RESET_BYTE;
      rise_select <= `SES_RESET_BYTE;
      fall_select <= `SES_RESET_BYTE;
      src_mask    <= `SES_RESET_BYTE;
    end else if (ce_i && do_write) begin
      case (cmd_sel_i)
        `SES_SEL_SRQ_MASK:    srq_mask    <= merge(srq_mask) & `SES_SRQ_VALID_BITS;
        `SES_SEL_STD_MASK:    std_mask    <= merge(std_mask);
        `SES_SEL_RISE_SELECT: rise_select <= merge(rise_select);
        `SES_SEL_FALL_SELECT: fall_select <= merge(fall_select);
        `SES_SEL_SRC_MASK:    src_mask    <= merge(src_mask);
        default: begin
        end
      endcase
    end
  end

  // Response, one cycle after a read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= `SES_RESET_BYTE;
    end else if (ce_i) begin
      rsp_valid_o <= do_read;
      if (do_read) begin
        rsp_data_o <= next_rsp;
      end
    end
  end

  // Registered summary outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_byte_o <= `SES_RESET_BYTE;
      mss_o         <= 1'b0;
    end else if (ce_i) begin
      status_byte_o <= status_byte;
      mss_o         <= mss;
    end
  end

endmodule

// >>> verification/ses_props.sv
// Port checker of the status event summary block.
// Assumes it is bound into ses_status_event_summary and sees only its ports.
`timescale 1ns/1ps
module ses_props (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire logic               cmd_valid_i,
  input wire logic               cmd_write_i,
  input wire ses_pkg::ses_sel_t  cmd_sel_i,
  input wire logic               cmd_single_i,
  input wire logic               overload_flag_i,
  input wire logic               interlock_i,
  input wire logic               rsp_valid_o,
  input wire ses_pkg::ses_byte_t rsp_data_o,
  input wire ses_pkg::ses_byte_t status_byte_o,
  input wire logic               mss_o
);
  import ses_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_q    = ce_i && cmd_valid_i && !cmd_write_i;
  wire logic rd_full = rd_q && !cmd_single_i;
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($fell(rst_i) |-> status_byte_o == 8'h00 && !mss_o && !rsp_valid_o)
    else $error("outputs not clear after reset");
  a_query_answer: assert property (rd_q |=> rsp_valid_o)
    else $error("query not answered");
  a_write_silent: assert property (ce_i && cmd_valid_i && cmd_write_i |=> !rsp_valid_o)
    else $error("setting gave an answer");
  a_cond_live: assert property (rd_full && cmd_sel_i == 4'h4 |=>
    rsp_data_o == {6'h00, $past(interlock_i), $past(overload_flag_i)})
    else $error("condition read not live");
  a_srq_bit_six: assert property (rd_full && cmd_sel_i == 4'h1 |=> !rsp_data_o[6])
    else $error("service mask bit 6 set");
  a_std_undef_zero: assert property (rd_full && cmd_sel_i == 4'h2 |=> !rsp_data_o[7] && !rsp_data_o[1])
    else $error("standard latch spare bit set");
  a_sb_undef_zero: assert property ((status_byte_o & 8'h9E) == 8'h00)
    else $error("status byte spare bit set");
  a_mss_copy: assert property (mss_o == status_byte_o[6])
    else $error("master summary differs from status byte");
  a_single_read: assert property (rd_q && cmd_single_i |=> rsp_data_o[7:1] == 7'h00)
    else $error("single bit answer wider than one bit");
  c_master: cover property (mss_o);
  c_src_read: cover property (rd_full && cmd_sel_i == 4'h7);
  c_esb: cover property (status_byte_o[5]);
endmodule

bind ses_status_event_summary ses_props u_props (.*);

// >>> verification/ses_host.sv
// Remote host model: issues settings and queries on the command port.
// Assumes queries are answered by a one-cycle strobe one edge after being taken.
`timescale 1ns/1ps
module ses_host (
  input  wire logic               clk_i,
  input  wire logic               rsp_valid_i,
  input  wire ses_pkg::ses_byte_t rsp_data_i,
  output logic                    cmd_valid_o,
  output logic                    cmd_write_o,
  output ses_pkg::ses_sel_t       cmd_sel_o,
  output logic                    cmd_single_o,
  output ses_pkg::ses_bit_t       cmd_bit_o,
  output ses_pkg::ses_byte_t      cmd_wdata_o
);
  import ses_pkg::*;
  initial begin
    {cmd_valid_o, cmd_write_o, cmd_single_o} = 3'h0;
    {cmd_sel_o, cmd_bit_o, cmd_wdata_o} = 15'h0;
  end
  // One request; the write data is scrambled once taken
  task automatic xfer(input logic wr, input ses_sel_t s, input logic sg, input ses_bit_t b,
                      input ses_byte_t wd, output ses_byte_t rd);
    @(posedge clk_i);
    {cmd_valid_o, cmd_write_o, cmd_single_o} <= {1'b1, wr, sg};
    {cmd_sel_o, cmd_bit_o, cmd_wdata_o} <= {s, b, wd};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_wdata_o <= ~wd;
    rd = 8'h00;
    if (!wr) begin
      @(posedge clk_i);
      rd = (rsp_valid_i === 1'b1) ? rsp_data_i : 8'hXX;
    end
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench of the status event summary block.
// Assumes ses_host drives the command port; events and conditions come from here.
`timescale 1ns/1ps
module tb;
  import ses_pkg::*;
  logic      clk_i, rst_i, ce_i, clear_status_i, rsp_valid_o, mss_o, cmd_valid_i, cmd_write_i, cmd_single_i;
  logic      opc_cmd_i, query_lost_i, overflow_i, exec_err_i, cmd_err_i, button_i, scan_cancel_i, scan_done_i;
  logic      overload_flag_i, interlock_i;
  ses_sel_t  cmd_sel_i;
  ses_bit_t  cmd_bit_i;
  ses_byte_t cmd_wdata_i, rsp_data_o, status_byte_o, got, m, r, f, e, ev;
  ses_cond_t cond, o;
  int        n_errors = 0;
  int        samples_checked = 0;
  assign {scan_done_i, scan_cancel_i, button_i, cmd_err_i, exec_err_i, overflow_i, query_lost_i, opc_cmd_i} = ev;
  assign {interlock_i, overload_flag_i} = cond;
  ses_status_event_summary DUT (.*);
  ses_host u_host (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_sel_o(cmd_sel_i), .cmd_single_o(cmd_single_i), .cmd_bit_o(cmd_bit_i),
    .cmd_wdata_o(cmd_wdata_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic ses_byte_t std_exp(input ses_byte_t x);
    return {1'b0, x[5:1], 1'b0, x[0]};
  endfunction
  function automatic ses_byte_t edge_exp(input ses_byte_t rs, fs, input ses_cond_t po, nw);
    return (rs & {6'h00, nw & ~po}) | (fs & {6'h00, po & ~nw});
  endfunction
  task automatic chk(input ses_byte_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic q(input ses_sel_t s, input logic sg = 1'b0, input ses_bit_t b = 3'h0);
    u_host.xfer(1'b0, s, sg, b, 8'h00, got);
  endtask
  task automatic w(input ses_sel_t s, input ses_byte_t d);
    u_host.xfer(1'b1, s, 1'b0, 3'h0, d, got);
  endtask
  task automatic pulse(input ses_byte_t x);
    @(posedge clk_i);
    ev <= x;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask
  task automatic clr();
    @(posedge clk_i);
    clear_status_i <= 1'b1;
    @(posedge clk_i);
    clear_status_i <= 1'b0;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hFBB47904));
    {rst_i, ce_i, clear_status_i, ev, cond} = {3'b110, 8'h00, 2'h0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 10; s++) begin
      q(4'(s));
      chk(got, 8'h00);
    end
    for (int s = 1; s < 10; s++) begin
      m = 8'($urandom);
      w(4'(s), m);
      q(4'(s));
      chk(got, (s == 1) ? (m & 8'hBF) : (s inside {3, 5, 6, 8}) ? m : 8'h00);
    end
    for (int k = 0; k < 6; k++) begin
      pulse(8'h01 << k);
      q(4'h2);
      chk(got, std_exp(8'h01 << k));
      q(4'h2);
      chk(got, 8'h00);
    end
    pulse(8'h03);
    q(4'h2, 1'b1, 3'h2);
    chk(got, 8'h01);
    q(4'h2);
    chk(got, 8'h01);
    w(4'h3, 8'h04);
    w(4'h1, 8'h20);
    pulse(8'h02);
    q(4'h0);
    chk(got, 8'h60);
    chk(status_byte_o, 8'h60);
    chk({7'h00, mss_o}, 8'h01);
    clr();
    q(4'h0);
    chk(got, 8'h00);
    fork
      pulse(8'h20);
      q(4'h2);
    join
    chk(got, 8'h00);
    q(4'h2);
    chk(got, 8'h40);
    w(4'h1, 8'h01);
    m = 8'($urandom);
    w(4'h8, m);
    for (int k = 0; k < 8; k++) begin
      r = 8'($urandom);
      f = 8'($urandom);
      w(4'h5, r);
      w(4'h6, f);
      @(posedge clk_i);
      o = cond;
      cond <= 2'($urandom);
      repeat (2) @(posedge clk_i);
      e = edge_exp(r, f, o, cond);
      q(4'h4);
      chk(got, {6'h00, cond});
      q(4'h0);
      chk(got, {1'b0, |(e & m), 5'h00, |(e & m)});
      q(4'h7);
      chk(got, e);
    end
    u_host.xfer(1'b1, 4'h8, 1'b1, 3'h3, 8'h01, got);
    q(4'h8);
    chk(got, m | 8'h08);
    u_host.xfer(1'b1, 4'h8, 1'b1, 3'h3, 8'h00, got);
    q(4'h8);
    chk(got, m & 8'hF7);
    q(4'h4, 1'b1, 3'h1);
    chk(got, {7'h00, cond[1]});
    pulse(8'hC0);
    q(4'h7, 1'b1, 3'h7);
    chk(got, 8'h01);
    q(4'h7);
    chk(got, 8'h40);
    pulse(8'h80);
    clr();
    q(4'h7);
    chk(got, 8'h00);
    @(posedge clk_i);
    ce_i <= 1'b0;
    pulse(8'h01);
    ce_i <= 1'b1;
    q(4'h2);
    chk(got, 8'h00);
    print_verdict();
  end
endmodule
